// ---- fspc_flash_ctrl.sv ----
// Flash self-programming controller: timed commands, page buffer, status.
`timescale 1ns/10ps
`default_nettype none

module fspc_flash_ctrl #(
    parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic store_program_op,
    input wire logic load_program_op,
    input wire logic [15:0] pointer_z,
    input wire logic page_extension_reg,
    input wire logic [15:0] data_word_pair,
    input wire logic eeprom_write_busy,
    input wire logic global_irq_enable,
    input wire logic [7:0] lock_byte_in,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [7:0] fuse_extended_byte,
    output logic [7:0] store_prog_ctrl_status,
    output logic spm_ready_irq,
    output logic cpu_stall,
    output logic live_read_block,
    output logic load_data_valid,
    output logic [7:0] load_data,
    output logic op_refused,
    output logic flash_erase_stb,
    output logic flash_prog_stb,
    output logic [15:0] flash_addr,
    output logic [15:0] flash_data,
    output logic lock_prog_stb,
    output logic [7:0] lock_prog_data
);

    localparam int TW = fspc_pkg::TIMER_W;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] arm;
        fspc_pkg::fspc_phase_e phase;
        fspc_pkg::fspc_op_e op;
        logic [8:0] page;
        logic halt_tgt;
        logic [6:0] widx;
        logic [127:0] valid;
        logic irq;
        logic stall;
        logic rd_block;
        logic ld_valid;
        logic [7:0] ld_data;
        logic refused;
        logic erase_stb;
        logic prog_stb;
        logic [15:0] faddr;
        logic [15:0] fdata;
        logic lock_stb;
        logic [7:0] lock_data;
    } fspc_state_s;

    fspc_state_s q;
    fspc_state_s d;

    logic [15:0] buf_mem [0:fspc_pkg::BUF_DEPTH-1];
    logic buf_we;
    logic [6:0] buf_waddr;
    logic [15:0] buf_wdata;
    logic tmr_start;
    logic tmr_clear;
    logic tmr_done;
    logic [4:0] cmd;
    logic op_busy;
    logic [6:0] ptr_word;
    logic [8:0] ptr_page;
    logic [15:0] stream_word;
    logic rst_all;

    assign cmd = q.ctrl[4:0];
    assign op_busy = (q.phase != fspc_pkg::PH_IDLE);
    assign ptr_word = pointer_z[7:1];
    assign ptr_page = {page_extension_reg, pointer_z[15:8]};
    assign stream_word = q.valid[q.widx] ? buf_mem[q.widx] : fspc_pkg::BLANK_WORD;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // One pass computes the whole next state; pulses default low.
    always_comb begin
        d = q;
        d.ld_valid = 1'b0;
        d.refused = 1'b0;
        d.erase_stb = 1'b0;
        d.prog_stb = 1'b0;
        d.lock_stb = 1'b0;
        buf_we = 1'b0;
        buf_waddr = ptr_word;
        buf_wdata = data_word_pair;
        tmr_start = 1'b0;

        // The window closes one step per cycle.
        if (q.arm != 3'h0) begin
            d.arm = q.arm - 3'h1;
        end
        if (q.arm == 3'h1 && !op_busy && !store_program_op) begin
            d.ctrl[4:0] = 5'h00;
        end

        if (ctrl_wr && !op_busy) begin
            d.ctrl[fspc_pkg::BIT_IRQ_EN] = ctrl_wdata[fspc_pkg::BIT_IRQ_EN];
            d.ctrl[4:0] = ctrl_wdata[4:0];
            d.arm = ctrl_wdata[fspc_pkg::BIT_SPM_EN] ? fspc_pkg::STORE_WINDOW : 3'h0;
            // read enable restores the live section
            if (ctrl_wdata[4:0] == fspc_pkg::CMD_READ_EN) begin
                d.ctrl[fspc_pkg::BIT_LIVE_BUSY] = 1'b0;
                d.valid = '0;
            end
        end else if (store_program_op && q.arm != 3'h0 && q.ctrl[fspc_pkg::BIT_SPM_EN]) begin
            d.arm = 3'h0;
            if (eeprom_write_busy) begin
                d.refused = 1'b1;
                d.ctrl[4:0] = 5'h00;
            end else begin
                case (cmd)
                    fspc_pkg::CMD_ERASE: begin
                        d.op = fspc_pkg::OP_ERASE;
                        d.phase = fspc_pkg::PH_TIMED;
                        d.page = ptr_page;
                        d.halt_tgt = (ptr_page >= fspc_pkg::HALT_FIRST_PAGE);
                        d.faddr = {ptr_page, 7'h00};
                        d.erase_stb = 1'b1;
                        tmr_start = 1'b1;
                        d.ctrl[fspc_pkg::BIT_LIVE_BUSY] =
                            (ptr_page < fspc_pkg::HALT_FIRST_PAGE);
                    end
                    fspc_pkg::CMD_FILL: begin
                        // store word; a second load is dropped
                        if (!q.valid[ptr_word]) begin
                            buf_we = 1'b1;
                            d.valid[ptr_word] = 1'b1;
                        end
                        d.ctrl[fspc_pkg::BIT_LIVE_BUSY] = 1'b0;
                        d.ctrl[4:0] = 5'h00;
                    end
                    fspc_pkg::CMD_WRITE: begin
                        // stream the buffer into the page
                        d.op = fspc_pkg::OP_WRITE;
                        d.phase = fspc_pkg::PH_STREAM;
                        d.page = ptr_page;
                        d.halt_tgt = (ptr_page >= fspc_pkg::HALT_FIRST_PAGE);
                        d.widx = 7'h00;
                        d.ctrl[fspc_pkg::BIT_LIVE_BUSY] =
                            (ptr_page < fspc_pkg::HALT_FIRST_PAGE);
                    end
                    fspc_pkg::CMD_LOCK: begin
                        // only bits 5:2 can be programmed
                        d.op = fspc_pkg::OP_LOCK;
                        d.phase = fspc_pkg::PH_TIMED;
                        d.halt_tgt = 1'b0;
                        d.lock_stb = 1'b1;
                        d.lock_data = data_word_pair[7:0] | fspc_pkg::LOCK_WR_KEEP;
                        tmr_start = 1'b1;
                    end
                    default: begin
                        d.ctrl[4:0] = 5'h00;
                    end
                endcase
            end
        end else if (load_program_op && q.arm > (fspc_pkg::STORE_WINDOW - fspc_pkg::LOAD_WINDOW)
                     && q.ctrl[fspc_pkg::BIT_SPM_EN] && q.ctrl[fspc_pkg::BIT_LOCK_SET]) begin
            // a timed read ends the sequence
            d.arm = 3'h0;
            d.ctrl[4:0] = 5'h00;
            if (eeprom_write_busy) begin
                d.refused = 1'b1;
            end else begin
                d.ld_valid = 1'b1;
                // pointer selects the byte; passed through uninverted, lock bits 7:6 read as one
                case (pointer_z)
                    fspc_pkg::PTR_FUSE_LOW: d.ld_data = fuse_low_byte;
                    fspc_pkg::PTR_LOCK: d.ld_data = lock_byte_in | fspc_pkg::LOCK_RD_UNUSED;
                    fspc_pkg::PTR_FUSE_EXT: d.ld_data = fuse_extended_byte;
                    fspc_pkg::PTR_FUSE_HIGH: d.ld_data = fuse_high_byte;
                    default: d.ld_data = 8'hFF;
                endcase
            end
        end

        // Write streaming: one buffer word per cycle, then the timed phase.
        if (q.phase == fspc_pkg::PH_STREAM) begin
            d.prog_stb = 1'b1;
            d.faddr = {q.page[8:0], q.widx};
            d.fdata = stream_word;
            d.widx = q.widx + 7'h01;
            if (q.widx == fspc_pkg::LAST_WORD) begin
                d.phase = fspc_pkg::PH_TIMED;
                tmr_start = 1'b1;
            end
        end

        if (q.phase == fspc_pkg::PH_TIMED && tmr_done) begin
            d.phase = fspc_pkg::PH_IDLE;
            d.ctrl[4:0] = 5'h00;
            if (q.op == fspc_pkg::OP_WRITE) begin
                d.valid = '0;
            end
            d.op = fspc_pkg::OP_NONE;
        end

        if (eeprom_write_busy) begin
            d.valid = '0;
        end

        // reset spares a running operation
        // An unknown phase at power-up falls to the default and is fully reset.
        case (q.phase)
            fspc_pkg::PH_STREAM: rst_all = 1'b0;
            fspc_pkg::PH_TIMED: rst_all = tmr_done;
            default: rst_all = 1'b1;
        endcase
        if (rst) begin
            d.ctrl[fspc_pkg::BIT_IRQ_EN] = 1'b0;
            // A streaming write still needs its words; its end empties the buffer.
            if (q.phase != fspc_pkg::PH_STREAM) begin
                d.valid = '0;
            end
            d.refused = 1'b0;
            d.ld_valid = 1'b0;
            d.ld_data = 8'h00;
            d.arm = 3'h0;
            if (rst_all) begin
                d = '0;
                d.ctrl = fspc_pkg::CTRL_RESET;
                d.phase = fspc_pkg::PH_IDLE;
                d.op = fspc_pkg::OP_NONE;
                tmr_start = 1'b0;
            end
        end

        // stall only for halting-section erase or write
        d.stall = (d.phase != fspc_pkg::PH_IDLE) && d.halt_tgt
                  && (d.op != fspc_pkg::OP_LOCK);
        // reads stay blocked while the busy flag stands
        d.rd_block = d.ctrl[fspc_pkg::BIT_LIVE_BUSY];
        // level interrupt while the enable bit is clear
        d.irq = d.ctrl[fspc_pkg::BIT_IRQ_EN] && global_irq_enable
                && !d.ctrl[fspc_pkg::BIT_SPM_EN];
    end

    // ------------------------------------------------------------------
    // Registers, buffer and timer
    // ------------------------------------------------------------------

    // All control state in one register; reset is folded into d.
    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    // Buffer data has no reset; the valid map decides what is real.
    always_ff @(posedge sys_clk) begin
        if (buf_we) begin
            buf_mem[buf_waddr] <= buf_wdata;
        end
    end

    // The timer keeps counting through reset so a write is never cut short.
    assign tmr_clear = rst && !op_busy;

    fspc_prog_timer #(
        .W(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .clear(tmr_clear),
        .start(tmr_start),
        .load(TW'(PROG_CYCLES)),
        .done(tmr_done),
        .running()
    );

    assign store_prog_ctrl_status = q.ctrl;
    assign spm_ready_irq = q.irq;
    assign cpu_stall = q.stall;
    assign live_read_block = q.rd_block;
    assign load_data_valid = q.ld_valid;
    assign load_data = q.ld_data;
    assign op_refused = q.refused;
    assign flash_erase_stb = q.erase_stb;
    assign flash_prog_stb = q.prog_stb;
    assign flash_addr = q.faddr;
    assign flash_data = q.fdata;
    assign lock_prog_stb = q.lock_stb;
    assign lock_prog_data = q.lock_data;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    sequence s_store_ok(logic [4:0] c);
        !rst && !ctrl_wr && store_program_op && q.arm != 3'h0
        && q.ctrl[fspc_pkg::BIT_SPM_EN] && !eeprom_write_busy && cmd == c;
    endsequence

    sequence s_stream8;
        flash_prog_stb [*8];
    endsequence

    a_erase_start: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_ok(fspc_pkg::CMD_ERASE) |=> flash_erase_stb && q.phase == fspc_pkg::PH_TIMED)
        else $error("Erase command did not start an erase.");

    a_fill_store: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_ok(fspc_pkg::CMD_FILL) |=> q.valid[$past(ptr_word)]
        && !store_prog_ctrl_status[fspc_pkg::BIT_LIVE_BUSY])
        else $error("Buffer load did not mark its word.");

    a_write_stream: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_ok(fspc_pkg::CMD_WRITE) |=> ##1 s_stream8)
        else $error("Page write did not stream the buffer.");

    a_stall_match: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_ok(fspc_pkg::CMD_ERASE) ##0 ptr_page >= fspc_pkg::HALT_FIRST_PAGE |=> cpu_stall)
        else $error("Stall does not follow the halting-section operation.");

    a_ee_drop: assert property (@(posedge sys_clk) disable iff (rst)
        eeprom_write_busy |=> q.valid == '0)
        else $error("Buffer kept words during an EEPROM write.");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        store_prog_ctrl_status[fspc_pkg::BIT_IRQ_EN] && global_irq_enable
        && !store_prog_ctrl_status[fspc_pkg::BIT_SPM_EN] && !ctrl_wr |=> spm_ready_irq)
        else $error("Ready interrupt dropped while enable bit clear.");

    a_busy_block: assert property (@(posedge sys_clk) disable iff (rst)
        q.phase != fspc_pkg::PH_IDLE && q.op != fspc_pkg::OP_LOCK && !q.halt_tgt
        && !ctrl_wr |=> live_read_block)
        else $error("Live section readable during its own programming.");

    a_ee_refuse: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_wr && !op_busy && store_program_op && eeprom_write_busy
        |=> !flash_erase_stb && !lock_prog_stb && q.phase == fspc_pkg::PH_IDLE)
        else $error("Programming started during an EEPROM write.");

    a_lock_read: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_wr && !store_program_op && load_program_op && q.arm > 3'h1
        && q.ctrl[fspc_pkg::BIT_LOCK_SET] && q.ctrl[fspc_pkg::BIT_SPM_EN]
        && !eeprom_write_busy && pointer_z == fspc_pkg::PTR_LOCK
        |=> load_data_valid && load_data == ($past(lock_byte_in) | 8'hC0)
        && !store_prog_ctrl_status[fspc_pkg::BIT_SPM_EN])
        else $error("Lock byte read wrong or enable not cleared.");

endmodule

`default_nettype wire

// ---- fspc_pkg.sv ----
// Constants and types shared by the flash self-programming controller.
package fspc_pkg;

    // ------------------------------------------------------------------
    // Control/status bit positions and reset value
    // ------------------------------------------------------------------
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_LIVE_BUSY = 6;
    localparam int BIT_READ_EN = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PG_WRITE = 2;
    localparam int BIT_PG_ERASE = 1;
    localparam int BIT_SPM_EN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Command patterns in control bits 4:0
    // ------------------------------------------------------------------
    localparam logic [4:0] CMD_FILL = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_READ_EN = 5'h11;

    // ------------------------------------------------------------------
    // Timed-sequence windows, in CPU cycles after the control write
    // ------------------------------------------------------------------
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;

    // ------------------------------------------------------------------
    // Pointer codes for fuse and lock reads
    // ------------------------------------------------------------------
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [7:0] LOCK_RD_UNUSED = 8'hC0;
    localparam logic [7:0] LOCK_WR_KEEP = 8'hC3;

    // ------------------------------------------------------------------
    // Flash geometry
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 7;
    localparam int PAGE_BITS = 9;
    localparam int BUF_DEPTH = 128;
    localparam logic [8:0] HALT_FIRST_PAGE = 9'h1E0;
    localparam logic [6:0] LAST_WORD = 7'h7F;
    localparam logic [15:0] BLANK_WORD = 16'hFFFF;

    // ------------------------------------------------------------------
    // Programming time at a 10 ns clock
    // ------------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int PROG_MIN_NS = 3700000;
    localparam int PROG_MAX_NS = 4500000;
    localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_NS;
    localparam int TIMER_W = 20;

    typedef enum logic [1:0] {PH_IDLE, PH_STREAM, PH_TIMED} fspc_phase_e;
    typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} fspc_op_e;

endpackage

// ---- fspc_prog_timer.sv ----
// Down-counter that times one flash programming operation.
`timescale 1ns/10ps
`default_nettype none

module fspc_prog_timer #(
    parameter int W = 20
) (
    input wire logic sys_clk,
    input wire logic clear,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done,
    output logic running
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
    } fspc_tmr_s;

    fspc_tmr_s q;
    fspc_tmr_s d;

    // Count down; clear is withheld by the owner while a write runs.
    always_comb begin
        d = q;
        if (clear) begin
            d.cnt = '0;
            d.run = 1'b0;
        end else if (start) begin
            d.cnt = load;
            d.run = 1'b1;
        end else if (q.run) begin
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == {{(W-1){1'b0}}, 1'b1}) begin
                d.run = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign done = q.run && (q.cnt == {{(W-1){1'b0}}, 1'b1});
    assign running = q.run;

endmodule

`default_nettype wire

// ---- fspc_cpu_model.sv ----
// CPU core model that issues timed control, store and load sequences.
`timescale 1ns/10ps
`default_nettype none
module fspc_cpu_model (
    input wire logic sys_clk,
    input wire logic [7:0] store_prog_ctrl_status,
    output logic ctrl_wr,
    output logic [7:0] ctrl_wdata,
    output logic store_program_op,
    output logic load_program_op,
    output logic [15:0] pointer_z,
    output logic page_extension_reg,
    output logic [15:0] data_word_pair
);
    // Quiet core at time zero.
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        store_program_op = 1'b0;
        load_program_op = 1'b0;
        pointer_z = 16'h0000;
        page_extension_reg = 1'b0;
        data_word_pair = 16'h0000;
    end

    // Poll the enable bit, as a boot loader does before each sequence.
    task automatic wait_idle;
        for (int k = 0; k < 500 && store_prog_ctrl_status[0] === 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    // gapless timed sequence
    // The op always follows the control write on the next cycle, so no
    // interrupt can push it out of the window.
    task automatic spm(input logic [7:0] v, input int op, input logic [15:0] z,
        input logic ext, input logic [15:0] d);
        wait_idle();
        @(posedge sys_clk);
        #1;
        pointer_z = z;
        page_extension_reg = ext;
        data_word_pair = d;
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(posedge sys_clk);
        #1;
        ctrl_wr = 1'b0;
        store_program_op = (op == 1);
        load_program_op = (op == 2);
        @(posedge sys_clk);
        #1;
        store_program_op = 1'b0;
        load_program_op = 1'b0;
        // A real core reuses its data registers at once.
        data_word_pair = ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb_fspc_flash_ctrl.sv ----
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            num_errors++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module tb_fspc_flash_ctrl;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic eeprom_write_busy = 1'b0;
    logic global_irq_enable = 1'b1;
    logic [7:0] lock_byte_in = 8'h25;
    logic [7:0] fuse_low_byte = 8'h5A;
    logic [7:0] fuse_high_byte = 8'h3C;
    logic [7:0] fuse_extended_byte = 8'hF1;
    logic ctrl_wr, store_program_op, load_program_op, page_extension_reg;
    logic [7:0] ctrl_wdata, store_prog_ctrl_status, load_data, lock_prog_data;
    logic [15:0] pointer_z, data_word_pair, flash_addr, flash_data, w0;
    logic spm_ready_irq, cpu_stall, live_read_block, load_data_valid;
    logic op_refused, flash_erase_stb, flash_prog_stb, lock_prog_stb;
    logic [7:0] exp_rd [4];
    int num_errors = 0, samples_checked = 0, cyc = 0;
    int n_prog = 0, n_ers = 0, n_lock = 0, n_val = 0, n_ref = 0;

    fspc_flash_ctrl #(.PROG_CYCLES(20)) u_dut (.sys_clk, .rst, .ctrl_wr, .ctrl_wdata,
        .store_program_op, .load_program_op, .pointer_z, .page_extension_reg,
        .data_word_pair, .eeprom_write_busy, .global_irq_enable, .lock_byte_in,
        .fuse_low_byte, .fuse_high_byte, .fuse_extended_byte, .store_prog_ctrl_status,
        .spm_ready_irq, .cpu_stall, .live_read_block, .load_data_valid, .load_data,
        .op_refused, .flash_erase_stb, .flash_prog_stb, .flash_addr, .flash_data,
        .lock_prog_stb, .lock_prog_data);
    fspc_cpu_model u_cpu (.sys_clk, .store_prog_ctrl_status, .ctrl_wr, .ctrl_wdata,
        .store_program_op, .load_program_op, .pointer_z, .page_extension_reg,
        .data_word_pair);

    // ------------------------------------------------------------------
    // Clock, strobe monitor and hang guard
    // ------------------------------------------------------------------
    always #5 sys_clk = ~sys_clk;

    // Pulses are counted here so that no single-cycle strobe is missed.
    always @(posedge sys_clk) begin
        cyc++;
        n_prog += (flash_prog_stb === 1'b1);
        n_ers += (flash_erase_stb === 1'b1);
        n_lock += (lock_prog_stb === 1'b1);
        n_val += (load_data_valid === 1'b1);
        n_ref += (op_refused === 1'b1);
        if (flash_prog_stb === 1'b1 && flash_addr === 16'h0080) w0 = flash_data;
        if (cyc == 8000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic clr(input string s);
        $display("test %s done", s);
        {n_prog, n_ers, n_lock, n_val, n_ref} = '0;
        w0 = 16'h0000;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        exp_rd = '{fuse_low_byte, lock_byte_in | fspc_pkg::LOCK_RD_UNUSED,
            fuse_extended_byte, fuse_high_byte};
        tick(10);
        rst = 1'b0;
        `CHK("ctrl", 8'h00, store_prog_ctrl_status); // reset value
        `CHK("irq", 1'b0, spm_ready_irq); // interrupt idle
        for (int i = 0; i < 4; i++) begin
            u_cpu.spm(8'h09, 2, 16'(i), 1'b0, 16'hFFFF);
            tick(2);
            `CHK("read", exp_rd[i], load_data); // read polarity
            `CHK("autoclr", 4'h0, store_prog_ctrl_status[3:0]); // auto clear
        end
        `CHK("valid", 32'h4, n_val); // one per read
        u_cpu.spm(8'h09, 0, 16'h0001, 1'b0, 16'hFFFF);
        tick(5);
        `CHK("expire", 5'h00, store_prog_ctrl_status[4:0]); // window expiry
        clr("reads");
        // one word, word bits zero, written out to page 1
        u_cpu.spm(8'h01, 1, 16'h0000, 1'b0, 16'h1234);
        u_cpu.spm(8'h85, 1, 16'h0100, 1'b0, 16'h0000);
        tick(2);
        `CHK("busy", 1'b1, store_prog_ctrl_status[6]); // busy flag
        `CHK("block", 1'b1, live_read_block); // reads blocked
        `CHK("stall", 1'b0, cpu_stall); // live target
        `CHK("enable", 1'b1, store_prog_ctrl_status[0]); // enable held
        u_cpu.wait_idle();
        tick(1);
        `CHK("words", fspc_pkg::BUF_DEPTH, n_prog); // page write
        `CHK("word0", 16'h1234, w0); // buffer load
        `CHK("irq", 1'b1, spm_ready_irq); // ready interrupt
        global_irq_enable = 1'b0;
        tick(1);
        `CHK("irqmask", 1'b0, spm_ready_irq); // global mask
        global_irq_enable = 1'b1;
        `CHK("busy", 1'b1, store_prog_ctrl_status[6]); // busy holds
        u_cpu.spm(8'h11, 0, 16'h0000, 1'b0, 16'h0000);
        `CHK("busy", 1'b0, store_prog_ctrl_status[6]); // read enable
        `CHK("irq", 1'b0, spm_ready_irq); // interrupt off
        clr("write");
        // Reset lands after word zero has streamed, so the buffer clear by read
        // enable is what shows in word zero.
        u_cpu.spm(8'h01, 1, 16'h0000, 1'b0, 16'h1234);
        u_cpu.spm(8'h11, 0, 16'h0000, 1'b0, 16'h0000);
        u_cpu.spm(8'h05, 1, 16'h0100, 1'b0, 16'h0000);
        tick(3);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        `CHK("keep", 1'b1, store_prog_ctrl_status[0]); // survives reset
        `CHK("busy", 1'b1, store_prog_ctrl_status[6]); // busy survives reset
        u_cpu.wait_idle();
        tick(1);
        `CHK("words", fspc_pkg::BUF_DEPTH, n_prog); // write completes
        `CHK("word0", 16'hFFFF, w0); // buffer cleared
        clr("reset");
        u_cpu.spm(8'h01, 1, 16'h0000, 1'b0, 16'h1234);
        eeprom_write_busy = 1'b1;
        tick(1);
        eeprom_write_busy = 1'b0;
        u_cpu.spm(8'h05, 1, 16'h0100, 1'b0, 16'h0000);
        u_cpu.wait_idle();
        tick(1);
        `CHK("word0", 16'hFFFF, w0); // words dropped
        u_cpu.spm(8'h01, 1, 16'h0002, 1'b0, 16'h5555);
        `CHK("busy", 1'b0, store_prog_ctrl_status[6]); // fill clears busy
        u_cpu.spm(8'h11, 0, 16'h0000, 1'b0, 16'h0000);
        clr("eeprom");
        u_cpu.spm(8'h03, 1, 16'hE100, 1'b1, 16'h0000);
        tick(2);
        `CHK("erase", 32'h1, n_ers); // page erase
        `CHK("eaddr", 16'hF080, flash_addr); // erase page address
        `CHK("stall", 1'b1, cpu_stall); // halting target
        u_cpu.wait_idle();
        tick(1);
        `CHK("stall", 1'b0, cpu_stall); // stall ends
        clr("erase");
        u_cpu.spm(8'h09, 1, 16'h0001, 1'b0, 16'h00C7);
        tick(2);
        `CHK("lock", 32'h1, n_lock); // lock strobe
        `CHK("lockdat", 8'hC7, lock_prog_data); // lock data
        `CHK("block", 1'b0, live_read_block); // flash readable
        `CHK("stall", 1'b0, cpu_stall); // no stall
        u_cpu.wait_idle();
        clr("lock");
        eeprom_write_busy = 1'b1;
        u_cpu.spm(8'h03, 1, 16'h0100, 1'b0, 16'h0000);
        u_cpu.spm(8'h09, 2, 16'h0001, 1'b0, 16'h0000);
        tick(2);
        `CHK("refused", 32'h2, n_ref); // refusals
        `CHK("erase", 32'h0, n_ers); // no erase
        `CHK("valid", 32'h0, n_val); // no read
        eeprom_write_busy = 1'b0;
        clr("refuse");
        stop_test();
    end
endmodule
`default_nettype wire
